// [hw/fpam_pkg.sv]
package fpam_pkg;

  // ************************************************************
  // apb register map, word aligned
  // ************************************************************
  localparam logic [11:0] OFS_CHG_ACT_C = 12'h000;
  localparam logic [11:0] OFS_DSG_ACT_A = 12'h004;
  localparam logic [11:0] OFS_DSG_ACT_B = 12'h008;
  localparam logic [11:0] OFS_DSG_ACT_C = 12'h00C;
  localparam logic [11:0] OFS_ENABLE_A = 12'h010;
  localparam logic [11:0] OFS_ENABLE_B = 12'h014;
  localparam logic [11:0] OFS_ENABLE_C = 12'h018;
  localparam logic [11:0] OFS_SAFETY_A = 12'h01C;
  localparam logic [11:0] OFS_SAFETY_B = 12'h020;
  localparam logic [11:0] OFS_SAFETY_C = 12'h024;
  localparam logic [11:0] OFS_FET_STATE = 12'h028;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] RST_CHG_ACT_C = 8'h56;
  localparam logic [7:0] RST_DSG_ACT_A = 8'hE4;
  localparam logic [7:0] RST_DSG_ACT_B = 8'hE6;
  localparam logic [7:0] RST_DSG_ACT_C = 8'hE2;
  localparam logic [7:0] RST_ENABLE = 8'h00;

  // ************************************************************
  // implemented bits; others are reserved and read zero
  // ************************************************************
  localparam logic [7:0] MSK_CHG_ACT_C = 8'h56;
  localparam logic [7:0] MSK_DSG_ACT_A = 8'hE4;
  localparam logic [7:0] MSK_DSG_ACT_B = 8'hE6;
  localparam logic [7:0] MSK_DSG_ACT_C = 8'hE2;
  localparam logic [7:0] MSK_GROUP_C = 8'hF6;

  // discharge action a values with guaranteed immediate turn-off
  localparam logic [7:0] DSG_A_FAST_0 = 8'h80;
  localparam logic [7:0] DSG_A_FAST_1 = 8'hE4;

  // fet state register bit positions
  localparam int FET_STATE_CHG_BIT = 0;
  localparam int FET_STATE_DSG_BIT = 1;

  // ************************************************************
  // timing
  // ************************************************************
  localparam longint CLK_HZ = 10_000_000;
  localparam longint DELAY_NORMAL_MS = 250;
  localparam longint DELAY_SLEEP_MS = 1000;
  localparam int DELAY_NORMAL_CYC = int'(DELAY_NORMAL_MS * CLK_HZ / 1000);
  localparam int DELAY_SLEEP_CYC = int'(DELAY_SLEEP_MS * CLK_HZ / 1000);
  localparam int TICK_W = 24;

  typedef logic [7:0] fpam_field_t;

endpackage : fpam_pkg

// [hw/fpam_tick_if.sv]
`timescale 1ns/100ps
interface fpam_tick_if;
  logic sleep;
  logic tick;

  modport timer
  (
    input sleep,
    output tick
  );

  modport user
  (
    output sleep,
    input tick
  );
endinterface : fpam_tick_if

// [hw/fpam_sync.sv]
`timescale 1ns/100ps
module fpam_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end
    else
    begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a bit moves only once the last two stages agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_out <= '0;
    else
      sync_out <= (s2_r & s3_r) | (sync_out & (s2_r | s3_r));
  end

endmodule : fpam_sync

// [hw/fpam_tick.sv]
`timescale 1ns/100ps
module fpam_tick #(
  parameter int NORMAL_CYC = fpam_pkg::DELAY_NORMAL_CYC,
  parameter int SLEEP_CYC = fpam_pkg::DELAY_SLEEP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  fpam_tick_if.timer tif
);

  logic [fpam_pkg::TICK_W-1:0] cnt_r;
  logic [fpam_pkg::TICK_W-1:0] last;

  assign last = tif.sleep ? fpam_pkg::TICK_W'(SLEEP_CYC - 1) : fpam_pkg::TICK_W'(NORMAL_CYC - 1);

  // counter restarts early if leaving sleep shortens the period under it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= '0;
      tif.tick <= 1'b0;
    end
    else if (cnt_r >= last)
    begin
      cnt_r <= '0;
      tif.tick <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 1'b1;
      tif.tick <= 1'b0;
    end
  end

endmodule : fpam_tick

// [hw/fpam_top.sv]
// Summary of operation
// - charge fet goes off when a triggered fault has its charge select bit set
// - discharge fet goes off when a triggered fault has its discharge select bit set
// - charge action field c is eight bits, resets to 0x56
// - charge field c: bit 6 latched short circuit, bit 4 latched overvoltage
// - charge field c: bit 2 precharge timeout, bit 1 host watchdog fault
// - discharge action field a is eight bits, resets to 0xE4
// - discharge field a: bit 7 short circuit, bit 6 tier2, bit 5 tier1 overcurrent
// - discharge field a: bit 2 cell undervoltage
// - field a other than 0x80/0xE4 may delay turn-off 250 ms or 1 s
// - discharge action field b is eight bits, resets to 0xE6
// - discharge field b: bits 7,6,5 fet, internal, discharge overtemperature
// - discharge field b: bit 2 internal, bit 1 discharge undertemperature
// - discharge action field c is eight bits, resets to 0xE2
// - discharge field c: bit 7 tier3, 6 latched short, 5 latched overcurrent
// - discharge field c: bit 1 host watchdog fault
// - each bit acts alone; reserved bits never affect fets
// - safety flag sets only while its protection is enabled
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/100ps
module fpam_top #(
  parameter int NORMAL_CYC = fpam_pkg::DELAY_NORMAL_CYC,
  parameter int SLEEP_CYC = fpam_pkg::DELAY_SLEEP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] fault_a,
  input wire logic [7:0] fault_b,
  input wire logic [7:0] fault_c,
  input wire logic sleep_mode,
  output logic charge_fet_off,
  output logic discharge_fet_off
);

  // ************************************************************
  // fault inputs and sleep come from other domains
  // ************************************************************
  logic [24:0] sync_q;
  fpam_sync #(.W(25)) u_sync
  (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({sleep_mode, fault_c, fault_b, fault_a}),
    .sync_out(sync_q)
  );

  fpam_pkg::fpam_field_t flt_a;
  fpam_pkg::fpam_field_t flt_b;
  fpam_pkg::fpam_field_t flt_c;
  assign flt_a = sync_q[7:0];
  assign flt_b = sync_q[15:8];
  assign flt_c = sync_q[23:16];

  fpam_tick_if tif();
  assign tif.sleep = sync_q[24];

  fpam_tick #(.NORMAL_CYC(NORMAL_CYC), .SLEEP_CYC(SLEEP_CYC)) u_tick
  (
    .pclk(pclk),
    .presetn(presetn),
    .tif(tif)
  );

  // ************************************************************
  // apb decode
  // ************************************************************
  logic wr_en;
  logic setup;
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign setup = psel && !penable;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic fpam_pkg::fpam_field_t any_sel(input fpam_pkg::fpam_field_t flag,
                                                     input fpam_pkg::fpam_field_t sel,
                                                     input fpam_pkg::fpam_field_t msk);
    any_sel = flag & sel & msk;
  endfunction : any_sel

  // ************************************************************
  // action and enable fields
  // ************************************************************
  fpam_pkg::fpam_field_t chg_c_r;
  fpam_pkg::fpam_field_t dsg_a_r;
  fpam_pkg::fpam_field_t dsg_b_r;
  fpam_pkg::fpam_field_t dsg_c_r;
  fpam_pkg::fpam_field_t en_a_r;
  fpam_pkg::fpam_field_t en_b_r;
  fpam_pkg::fpam_field_t en_c_r;

  // reserved positions are never stored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chg_c_r <= fpam_pkg::RST_CHG_ACT_C;
      dsg_a_r <= fpam_pkg::RST_DSG_ACT_A;
      dsg_b_r <= fpam_pkg::RST_DSG_ACT_B;
      dsg_c_r <= fpam_pkg::RST_DSG_ACT_C;
    end
    else if (wr_en)
    begin
      if (hit(paddr, fpam_pkg::OFS_CHG_ACT_C))
        chg_c_r <= pwdata[7:0] & fpam_pkg::MSK_CHG_ACT_C;
      else if (hit(paddr, fpam_pkg::OFS_DSG_ACT_A))
        dsg_a_r <= pwdata[7:0] & fpam_pkg::MSK_DSG_ACT_A;
      else if (hit(paddr, fpam_pkg::OFS_DSG_ACT_B))
        dsg_b_r <= pwdata[7:0] & fpam_pkg::MSK_DSG_ACT_B;
      else if (hit(paddr, fpam_pkg::OFS_DSG_ACT_C))
        dsg_c_r <= pwdata[7:0] & fpam_pkg::MSK_DSG_ACT_C;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_a_r <= fpam_pkg::RST_ENABLE;
      en_b_r <= fpam_pkg::RST_ENABLE;
      en_c_r <= fpam_pkg::RST_ENABLE;
    end
    else if (wr_en)
    begin
      if (hit(paddr, fpam_pkg::OFS_ENABLE_A))
        en_a_r <= pwdata[7:0] & fpam_pkg::MSK_DSG_ACT_A;
      else if (hit(paddr, fpam_pkg::OFS_ENABLE_B))
        en_b_r <= pwdata[7:0] & fpam_pkg::MSK_DSG_ACT_B;
      else if (hit(paddr, fpam_pkg::OFS_ENABLE_C))
        en_c_r <= pwdata[7:0] & fpam_pkg::MSK_GROUP_C;
    end
  end

  // ************************************************************
  // safety status, sticky, write one to clear
  // ************************************************************
  fpam_pkg::fpam_field_t stat_a_r;
  fpam_pkg::fpam_field_t stat_b_r;
  fpam_pkg::fpam_field_t stat_c_r;
  fpam_pkg::fpam_field_t clr_a;
  fpam_pkg::fpam_field_t clr_b;
  fpam_pkg::fpam_field_t clr_c;

  assign clr_a = (wr_en && hit(paddr, fpam_pkg::OFS_SAFETY_A)) ? pwdata[7:0] : 8'h00;
  assign clr_b = (wr_en && hit(paddr, fpam_pkg::OFS_SAFETY_B)) ? pwdata[7:0] : 8'h00;
  assign clr_c = (wr_en && hit(paddr, fpam_pkg::OFS_SAFETY_C)) ? pwdata[7:0] : 8'h00;

  // a fault still present wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_a_r <= 8'h00;
      stat_b_r <= 8'h00;
      stat_c_r <= 8'h00;
    end
    else
    begin
      stat_a_r <= (stat_a_r & ~clr_a) | (flt_a & en_a_r);
      stat_b_r <= (stat_b_r & ~clr_b) | (flt_b & en_b_r);
      stat_c_r <= (stat_c_r & ~clr_c) | (flt_c & en_c_r);
    end
  end

  // ************************************************************
  // fet action map
  // ************************************************************
  logic chg_req;
  logic dsg_a_raw;
  logic dsg_a_fast;
  logic dsg_a_hold_r;
  logic dsg_req;

  assign chg_req = |any_sel(stat_c_r, chg_c_r, fpam_pkg::MSK_CHG_ACT_C);
  assign dsg_a_raw = |any_sel(stat_a_r, dsg_a_r, fpam_pkg::MSK_DSG_ACT_A);
  assign dsg_a_fast = (dsg_a_r == fpam_pkg::DSG_A_FAST_0) || (dsg_a_r == fpam_pkg::DSG_A_FAST_1);

  // other field a values only get the slow periodic evaluation
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dsg_a_hold_r <= 1'b0;
    else if (tif.tick)
      dsg_a_hold_r <= dsg_a_raw;
  end

  assign dsg_req = (dsg_a_fast ? dsg_a_raw : dsg_a_hold_r)
                 | (|any_sel(stat_b_r, dsg_b_r, fpam_pkg::MSK_DSG_ACT_B))
                 | (|any_sel(stat_c_r, dsg_c_r, fpam_pkg::MSK_DSG_ACT_C));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      charge_fet_off <= 1'b0;
      discharge_fet_off <= 1'b0;
    end
    else
    begin
      charge_fet_off <= chg_req;
      discharge_fet_off <= dsg_req;
    end
  end

  // ************************************************************
  // apb read data, captured in the setup cycle
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (hit(paddr, fpam_pkg::OFS_CHG_ACT_C))
        prdata[7:0] <= chg_c_r;
      else if (hit(paddr, fpam_pkg::OFS_DSG_ACT_A))
        prdata[7:0] <= dsg_a_r;
      else if (hit(paddr, fpam_pkg::OFS_DSG_ACT_B))
        prdata[7:0] <= dsg_b_r;
      else if (hit(paddr, fpam_pkg::OFS_DSG_ACT_C))
        prdata[7:0] <= dsg_c_r;
      else if (hit(paddr, fpam_pkg::OFS_ENABLE_A))
        prdata[7:0] <= en_a_r;
      else if (hit(paddr, fpam_pkg::OFS_ENABLE_B))
        prdata[7:0] <= en_b_r;
      else if (hit(paddr, fpam_pkg::OFS_ENABLE_C))
        prdata[7:0] <= en_c_r;
      else if (hit(paddr, fpam_pkg::OFS_SAFETY_A))
        prdata[7:0] <= stat_a_r;
      else if (hit(paddr, fpam_pkg::OFS_SAFETY_B))
        prdata[7:0] <= stat_b_r;
      else if (hit(paddr, fpam_pkg::OFS_SAFETY_C))
        prdata[7:0] <= stat_c_r;
      else if (hit(paddr, fpam_pkg::OFS_FET_STATE))
      begin
        prdata[fpam_pkg::FET_STATE_CHG_BIT] <= charge_fet_off;
        prdata[fpam_pkg::FET_STATE_DSG_BIT] <= discharge_fet_off;
      end
      else
        pslverr <= 1'b1;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic wr_chg_c_seen_r;
  logic wr_dsg_seen_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_chg_c_seen_r <= 1'b0;
      wr_dsg_seen_r <= 1'b0;
    end
    else if (wr_en)
    begin
      wr_chg_c_seen_r <= wr_chg_c_seen_r | hit(paddr, fpam_pkg::OFS_CHG_ACT_C);
      wr_dsg_seen_r <= wr_dsg_seen_r | hit(paddr, fpam_pkg::OFS_DSG_ACT_A)
                     | hit(paddr, fpam_pkg::OFS_DSG_ACT_B) | hit(paddr, fpam_pkg::OFS_DSG_ACT_C);
    end
  end

  chg_c_reset_a: assert property (!wr_chg_c_seen_r |-> chg_c_r == 8'h56)
    else $error("charge field c lost its reset value");
  dsg_a_reset_a: assert property (!wr_dsg_seen_r |-> dsg_a_r == 8'hE4)
    else $error("discharge field a lost its reset value");
  dsg_b_reset_a: assert property (!wr_dsg_seen_r |-> dsg_b_r == 8'hE6)
    else $error("discharge field b lost its reset value");
  dsg_c_reset_a: assert property (!wr_dsg_seen_r |-> dsg_c_r == 8'hE2)
    else $error("discharge field c lost its reset value");
  chg_latched_short_a: assert property (stat_c_r[6] && chg_c_r[6] |=> charge_fet_off)
    else $error("latched short did not turn charge fet off");
  chg_idle_a: assert property ((stat_c_r & chg_c_r) == 8'h00 |=> !charge_fet_off)
    else $error("charge fet off with no selected fault");
  chg_timeout_a: assert property (stat_c_r[2] && chg_c_r[2] ##1 stat_c_r[2] |-> charge_fet_off)
    else $error("precharge timeout did not turn charge fet off");
  dsg_short_a: assert property (dsg_a_fast && stat_a_r[7] && dsg_a_r[7] |=> discharge_fet_off)
    else $error("short circuit did not turn discharge fet off");
  dsg_overtemp_a: assert property (stat_b_r[7] && dsg_b_r[7] |=> discharge_fet_off)
    else $error("fet overtemperature did not turn discharge fet off");
  dsg_watchdog_a: assert property (stat_c_r[1] && dsg_c_r[1] |=> discharge_fet_off)
    else $error("watchdog fault did not turn discharge fet off");
  slow_hold_a: assert property (!tif.tick |=> $stable(dsg_a_hold_r))
    else $error("slow field a path moved without a tick");
  enable_gate_a: assert property ((stat_c_r & ~$past(stat_c_r) & ~$past(en_c_r)) == 8'h00)
    else $error("safety flag set while protection disabled");
  reserved_zero_a: assert property ((dsg_c_r & ~fpam_pkg::MSK_DSG_ACT_C) == 8'h00)
    else $error("reserved discharge bit stored");

  // ************************************************************
  // per fault action checks
  // ************************************************************
  // each selected fault alone must reach its fet, whatever the others hold
  chg_overvolt_a: assert property (stat_c_r[4] && chg_c_r[4] |=> charge_fet_off)
    else $error("latched overvoltage did not turn charge fet off");
  chg_watchdog_a: assert property (stat_c_r[1] && chg_c_r[1] |=> charge_fet_off)
    else $error("watchdog fault did not turn charge fet off");
  dsg_undervolt_a: assert property (dsg_a_fast && stat_a_r[2] && dsg_a_r[2] |=> discharge_fet_off)
    else $error("cell undervoltage did not turn discharge fet off");
  dsg_undertemp_a: assert property (stat_b_r[1] && dsg_b_r[1] |=> discharge_fet_off)
    else $error("discharge undertemperature did not turn discharge fet off");
  dsg_latched_a: assert property (stat_c_r[6] && dsg_c_r[6] |=> discharge_fet_off)
    else $error("latched short did not turn discharge fet off");
  chg_reserved_a: assert property ((chg_c_r & ~fpam_pkg::MSK_CHG_ACT_C) == 8'h00)
    else $error("reserved charge bit stored");
  dsg_idle_a: assert property ((stat_b_r & dsg_b_r) == 8'h00 && (stat_c_r & dsg_c_r) == 8'h00 && !dsg_a_raw
                               && !dsg_a_hold_r |=> !discharge_fet_off)
    else $error("discharge fet off with no selected fault");

  fast_path_c: cover property (dsg_a_fast && dsg_a_raw ##1 discharge_fet_off);

  chg_off_c: cover property ($rose(charge_fet_off));
  dsg_off_c: cover property ($rose(discharge_fet_off));
  slow_path_c: cover property (!dsg_a_fast && dsg_a_raw ##1 tif.tick);
  clear_c: cover property ($fell(stat_c_r[1]));

endmodule : fpam_top

// [dv/fpam_fet_gate_model.sv]
`timescale 1ns/100ps
module fpam_fet_gate_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic charge_fet_off,
  input wire logic discharge_fet_off,
  output logic charge_fet_on,
  output logic discharge_fet_on
);
  // ************************************************************
  // gate drive stage
  // ************************************************************
  // gates stay off in reset; a driver never turns on before it is told to
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      charge_fet_on <= 1'b0;
      discharge_fet_on <= 1'b0;
    end
    else
    begin
      charge_fet_on <= !charge_fet_off;
      discharge_fet_on <= !discharge_fet_off;
    end
  end
endmodule : fpam_fet_gate_model

// [dv/fpam_top_tb_top.sv]
`timescale 1ns/100ps
module fpam_top_tb_top;
  localparam int NCYC = 20;
  localparam int SCYC = 40;
  localparam logic [11:0] ACT [4] = '{fpam_pkg::OFS_CHG_ACT_C, fpam_pkg::OFS_DSG_ACT_A,
    fpam_pkg::OFS_DSG_ACT_B, fpam_pkg::OFS_DSG_ACT_C};
  localparam logic [7:0] ACT_RST [4] = '{8'h56, 8'hE4, 8'hE6, 8'hE2};
  localparam logic [11:0] ENA [3] = '{fpam_pkg::OFS_ENABLE_A, fpam_pkg::OFS_ENABLE_B, fpam_pkg::OFS_ENABLE_C};
  localparam logic [11:0] SAF [3] = '{fpam_pkg::OFS_SAFETY_A, fpam_pkg::OFS_SAFETY_B, fpam_pkg::OFS_SAFETY_C};
  localparam logic [7:0] PINS [3] = '{8'hE4, 8'hE6, 8'hF6};
  localparam logic [7:0] DSG_SEL [3] = '{8'hE4, 8'hE6, 8'hE2};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] fault [3] = '{default: 8'h00};
  logic sleep_mode = 1'b0;
  logic chg_off;
  logic dsg_off;
  logic chg_on;
  logic dsg_on;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;

  fpam_top #(.NORMAL_CYC(NCYC), .SLEEP_CYC(SCYC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fault_a(fault[0]), .fault_b(fault[1]), .fault_c(fault[2]), .sleep_mode(sleep_mode),
    .charge_fet_off(chg_off), .discharge_fet_off(dsg_off));

  fpam_fet_gate_model gate (.pclk(pclk), .presetn(presetn), .charge_fet_off(chg_off),
    .discharge_fet_off(dsg_off), .charge_fet_on(chg_on), .discharge_fet_on(dsg_on));

  always #50 pclk = !pclk;

  // ************************************************************
  // reporting
  // ************************************************************
  task automatic conclude;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // hang guard, well above the roughly 1200 cycles the tests need
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      conclude();
    end
  end

  task automatic check_bit(input string name, input logic e, input logic g);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected %s expected %b seen %b", name, e, g);
    end
  endtask : check_bit

  task automatic check_word(input string name, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, e, g);
    end
  endtask : check_word

  // ************************************************************
  // apb master
  // ************************************************************
  task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      miscompares++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb_xfer

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic err;
    apb_xfer(1'b1, a, {24'h000000, d}, rd, err);
  endtask : wr

  task automatic rd_chk(input string name, input logic [11:0] a, input logic [7:0] e, input logic e_err);
    logic [31:0] rd;
    logic err;
    apb_xfer(1'b0, a, 32'h00000000, rd, err);
    check_word(name, {24'h000000, e}, rd);
    check_bit({name, " slverr"}, e_err, err);
    check_bit({name, " ready"}, 1'b1, pready);
  endtask : rd_chk

  // ************************************************************
  // one protection trip and its clear
  // ************************************************************
  // lim covers sync, status and output stages, or a whole slow tick period
  task automatic trip(input int g, input int b, input logic [7:0] en, input logic ec, input logic ed,
    input int lim);
    logic [7:0] one;
    one = 8'h01 << b;
    wr(ENA[g], en);
    fault[g][b] <= 1'b1;
    repeat (lim) @(posedge pclk);
    check_bit("charge off", ec, chg_off);
    check_bit("discharge off", ed, dsg_off);
    check_bit("discharge gate", !ed, dsg_on);
    check_bit("charge gate", !ec, chg_on);
    rd_chk("safety status", SAF[g], en & one, 1'b0);
    rd_chk("enable", ENA[g], en & PINS[g], 1'b0);
    rd_chk("fet state", fpam_pkg::OFS_FET_STATE, {6'h00, ed, ec}, 1'b0);
    fault[g][b] <= 1'b0;
    repeat (6) @(posedge pclk);
    wr(SAF[g], one);
    wr(ENA[g], 8'h00);
    repeat (lim) @(posedge pclk);
    check_bit("charge off cleared", 1'b0, chg_off);
    check_bit("discharge off cleared", 1'b0, dsg_off);
  endtask : trip

  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check_bit("charge off at reset", 1'b0, chg_off);
    check_bit("discharge off at reset", 1'b0, dsg_off);
    rd_chk("unmapped", 12'hFFC, 8'h00, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      rd_chk("action reset", ACT[i], ACT_RST[i], 1'b0);
      wr(ACT[i], 8'hFF);
      rd_chk("action all ones", ACT[i], ACT_RST[i], 1'b0);
      wr(ACT[i], 8'h00);
      rd_chk("action zero", ACT[i], 8'h00, 1'b0);
      wr(ACT[i], ACT_RST[i]);
    end
    $display("test registers done");
    for (int g = 0; g < 3; g++)
      for (int b = 0; b < 8; b++)
        if (PINS[g][b])
          trip(g, b, 8'h01 << b, (g == 2) && ACT_RST[0][b], DSG_SEL[g][b], 10);
    $display("test fault map done");
    trip(2, 1, 8'h00, 1'b0, 1'b0, 10);
    $display("test disabled done");
    wr(fpam_pkg::OFS_CHG_ACT_C, 8'h02);
    wr(fpam_pkg::OFS_DSG_ACT_C, 8'h40);
    wr(fpam_pkg::OFS_DSG_ACT_A, 8'h80);
    trip(2, 1, 8'hF6, 1'b1, 1'b0, 10);
    trip(2, 6, 8'hF6, 1'b0, 1'b1, 10);
    trip(0, 6, 8'hE4, 1'b0, 1'b0, 10);
    trip(0, 7, 8'hE4, 1'b0, 1'b1, 10);
    wr(fpam_pkg::OFS_CHG_ACT_C, 8'h56);
    wr(fpam_pkg::OFS_DSG_ACT_C, 8'hE2);
    $display("test independence done");
    // a slow field a value only acts on the period tick
    wr(fpam_pkg::OFS_DSG_ACT_A, 8'hA0);
    trip(0, 5, 8'h20, 1'b0, 1'b1, NCYC + 12);
    sleep_mode <= 1'b1;
    trip(0, 5, 8'h20, 1'b0, 1'b1, SCYC + 12);
    sleep_mode <= 1'b0;
    wr(fpam_pkg::OFS_DSG_ACT_A, 8'hE4);
    $display("test delayed done");
    conclude();
  end
endmodule : fpam_top_tb_top
